// [core/id_readback_commands.sv]
// How it works
// - Command byte DBh with select low starts a version identifier read.
// - Command byte DCh with select low starts a module identifier read.
// - First parameter read after either command returns a dummy byte.
// - Second read after DBh drives the 8-bit version identifier.
// - Version identifier top bit is forced to one, range 80h to FFh.
// - Programmed store replaces the built-in version identifier.
// - Second read after DCh drives the full 8-bit module identifier.
// - Programmed store replaces the built-in module identifier.
// - Every reset reloads both identifiers from built-in or stored value.
// - Both commands work regardless of display, idle or sleep state.
`include "id_readback_defines.svh"
`default_nettype none
module id_readback_commands (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Software reset pulse from the command decoder
	input wire logic softReset,
	// Host bus pins
	input wire logic data_command_select,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [7:0] hostDataIn,
	output logic [7:0] hostDataOut,
	output logic hostDataOe,
	// Non-volatile store contents
	input wire logic nonvolatile_program_store,
	input wire logic [7:0] storedVersionId,
	input wire logic [7:0] storedModuleId,
	// Identifier read-back
	output logic [7:0] version_identifier,
	output logic [7:0] module_identifier
);
	// Whole state of the block, registered in one place
	typedef struct packed {
		// Read-back sequencing
		id_readback_pkg::phase_t phase;
		id_readback_pkg::sel_t sel;
		// Identifiers as the host sees them
		logic [7:0] versionId;
		logic [7:0] moduleId;
		// Registered bus drive
		logic [7:0] dataOut;
		logic oe;
		// Three pin stages for select and data, as for the strobes
		logic selD1;
		logic selD2;
		logic selD3;
		logic [7:0] dataD1;
		logic [7:0] dataD2;
		logic [7:0] dataD3;
		// Identifier reload pending after reset release
		logic reload;
	} state_t;

	// Registered state and its next value
	state_t state;
	state_t next_state;

	// Filtered strobes from the two pin samplers
	strobe_sync_if rdSync();
	strobe_sync_if wrSync();

	// Strobe events, all but the read release qualified by select, and the pair a reset loads
	logic cmdWrite;
	logic paramRead;
	logic paramRelease;
	logic [7:0] loadVersionId;
	logic [7:0] loadModuleId;

	// Strobes are asynchronous to mclk and get filtered before use
	pin_sync readSampler (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin(read_strobe_n),
		.idleLevel(1'b1),
		.sync(rdSync.producer)
	);

	// Command bytes are taken on the rising write strobe
	pin_sync writeSampler (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pin(write_strobe_n),
		.idleLevel(1'b1),
		.sync(wrSync.producer)
	);

	// Write with select low is a command; read with select high drives a parameter
	assign cmdWrite = wrSync.rise & ~state.selD3;
	assign paramRead = rdSync.fall & state.selD3;
	// Release steps the phase whatever select shows, so a sequence never stalls
	assign paramRelease = rdSync.rise;

	// Stored pair once programmed, else the built-in pair
	assign loadVersionId = nonvolatile_program_store ?
		storedVersionId : `VERSION_ID_BUILTIN;
	assign loadModuleId = nonvolatile_program_store ?
		storedModuleId : `MODULE_ID_BUILTIN;

	// One copy of the state is filled here and registered below
	always_comb begin
		next_state = state;
		// Select and data stay stable for many clocks around a strobe edge
		next_state.selD1 = data_command_select;
		next_state.selD2 = state.selD1;
		next_state.selD3 = state.selD2;
		next_state.dataD1 = hostDataIn;
		next_state.dataD2 = state.dataD1;
		next_state.dataD3 = state.dataD2;
		// Reload is a one-cycle request
		next_state.reload = 1'b0;
		// Every reset loads the same pair; top bit forced so the range stays 80h up
		if (state.reload || softReset) begin
			next_state.versionId = loadVersionId | `VERSION_ID_MSB;
			next_state.moduleId = loadModuleId;
		end

		// No sleep or mode input gates decoding
		if (cmdWrite) begin
			// Any command drops the bus and abandons a read-back in flight
			next_state.oe = 1'b0;
			unique case (state.dataD3)
				// Version identifier sequence
				`CMD_READ_VERSION_ID: begin
					next_state.phase = id_readback_pkg::PH_DUMMY;
					next_state.sel = id_readback_pkg::SEL_VERSION;
				end
				// Module identifier; any selection but version picks it later
				`CMD_READ_MODULE_ID: begin
					next_state.phase = id_readback_pkg::PH_DUMMY;
					next_state.sel = id_readback_pkg::SEL_NONE;
				end
				// Other commands belong elsewhere and end any sequence
				default: begin
					next_state.phase = id_readback_pkg::PH_IDLE;
				end
			endcase
		end

		// Bus is driven only while the filtered read strobe is low
		if (paramRead) begin
			unique case (state.phase)
				// First byte carries no information; the host throws it away
				id_readback_pkg::PH_DUMMY: begin
					next_state.dataOut = `DUMMY_BYTE;
					next_state.oe = 1'b1;
				end
				// Second byte is the identifier the command asked for
				id_readback_pkg::PH_ID: begin
					next_state.oe = 1'b1;
					if (state.sel == id_readback_pkg::SEL_VERSION) begin
						next_state.dataOut = state.versionId;
					end else begin
						next_state.dataOut = state.moduleId;
					end
				end
				// Nothing pending: leave the bus to others
				default: begin
					next_state.oe = 1'b0;
				end
			endcase
		end

		// Advance on release so each strobe steps one byte
		if (paramRelease) begin
			next_state.oe = 1'b0;
			unique case (state.phase)
				// Dummy byte done, identifier comes next
				id_readback_pkg::PH_DUMMY: begin
					next_state.phase = id_readback_pkg::PH_ID;
				end
				// Identifier done; further reads find nothing to drive
				id_readback_pkg::PH_ID: begin
					next_state.phase = id_readback_pkg::PH_DONE;
				end
				// Idle and done stay put
				default: begin
					next_state.phase = state.phase;
				end
			endcase
		end
	end

	// Reset loads constants; identifiers are reloaded the cycle after release
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= '{
				phase: id_readback_pkg::PH_IDLE,
				sel: id_readback_pkg::SEL_NONE,
				versionId: `VERSION_ID_MSB,
				moduleId: `BYTE_RESET,
				dataOut: `BYTE_RESET,
				oe: 1'b0,
				selD1: 1'b1,
				selD2: 1'b1,
				selD3: 1'b1,
				dataD1: `BYTE_RESET,
				dataD2: `BYTE_RESET,
				dataD3: `BYTE_RESET,
				reload: 1'b1
			};
		end else begin
			state <= next_state;
		end
	end

	// Bus drive straight from flip-flops
	assign hostDataOut = state.dataOut;
	// Enable is registered too, so the pad turns around on a clean edge
	assign hostDataOe = state.oe;

	// Identifiers straight from flip-flops
	assign version_identifier = state.versionId;
	assign module_identifier = state.moduleId;
endmodule
`default_nettype wire

// [core/id_readback_defines.svh]
`ifndef ID_READBACK_DEFINES_SVH
`define ID_READBACK_DEFINES_SVH

// Command codes seen with the select line low
`define CMD_READ_VERSION_ID 8'hdb
`define CMD_READ_MODULE_ID 8'hdc

// Built-in values used until the store is programmed (arbitrary neutral values)
`define VERSION_ID_BUILTIN 8'ha5
`define MODULE_ID_BUILTIN 8'h5a

// Version identifier always has its top bit set
`define VERSION_ID_MSB 8'h80

// Byte driven on the dummy read
`define DUMMY_BYTE 8'h00

// Reset value of the byte-wide state registers other than the version identifier
`define BYTE_RESET 8'h00

`endif

// [core/id_readback_pkg.sv]
`default_nettype none
package id_readback_pkg;
	// Phase of the read-back after a command
	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001,
		PH_DUMMY = 4'b0010,
		PH_ID = 4'b0100,
		PH_DONE = 4'b1000
	} phase_t;

	// Which identifier the pending command asked for
	typedef enum logic [1:0] {
		SEL_NONE = 2'b01,
		SEL_VERSION = 2'b10
	} sel_t;

	// Filtered strobe sampler state
	typedef struct packed {
		logic [2:0] shift;
		logic level;
	} sync_state_t;
endpackage
`default_nettype wire

// [core/strobe_sync_if.sv]
`default_nettype none
interface strobe_sync_if;
	logic level;
	logic fall;
	logic rise;
	modport producer (output level, output fall, output rise);
	modport consumer (input level, input fall, input rise);
endinterface
`default_nettype wire

// [core/pin_sync.sv]
`default_nettype none
module pin_sync (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Raw pin, reset level
	input wire logic pin,
	input wire logic idleLevel,
	// Filtered level and edges
	strobe_sync_if.producer sync
);
	id_readback_pkg::sync_state_t state;
	id_readback_pkg::sync_state_t next_state;

	// A change counts only once the second and third stages agree
	// Stages hold the pin relative to its idle level, so an all-zero reset
	// means idle and no false edge follows the release of reset
	always_comb begin
		next_state = state;
		next_state.shift = {state.shift[1:0], pin ^ idleLevel};
		if (state.shift[1] == state.shift[2]) begin
			next_state.level = state.shift[2];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= '{shift: 3'b000, level: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	// Filtered level now and one cycle on, back in pin polarity
	logic levelNow;
	logic levelNext;
	assign levelNow = state.level ^ idleLevel;
	assign levelNext = next_state.level ^ idleLevel;
	assign sync.level = levelNow;
	assign sync.fall = levelNow & ~levelNext;
	assign sync.rise = ~levelNow & levelNext;
endmodule
`default_nettype wire

// [bench/readback_monitor.sv]
`include "id_readback_defines.svh"
`default_nettype none
module readback_monitor (
	// Clock and resets
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic softReset,
	// Host strobes
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	// Read-back drive
	input wire logic hostDataOe,
	input wire logic [7:0] hostDataOut,
	// Store contents
	input wire logic nonvolatile_program_store,
	input wire logic [7:0] storedVersionId,
	input wire logic [7:0] storedModuleId,
	// Identifiers
	input wire logic [7:0] version_identifier,
	input wire logic [7:0] module_identifier
);
	timeunit 1ns;
	timeprecision 100ps;
	// Pair any reset must load; top bit is forced on the stored value too
	wire logic [15:0] ids = {version_identifier, module_identifier};
	wire logic [15:0] expIds = nonvolatile_program_store ?
		{storedVersionId | `VERSION_ID_MSB, storedModuleId} :
		{`VERSION_ID_BUILTIN | `VERSION_ID_MSB, `MODULE_ID_BUILTIN};
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_reset_floor: assert property ($fell(sys_rst) |-> version_identifier == `VERSION_ID_MSB)
		else $error("reset value");
	a_reset_load: assert property ($fell(sys_rst) |-> ##2 ids == expIds)
		else $error("reset load");
	a_soft_reload: assert property (softReset |-> ##2 ids == expIds)
		else $error("soft reload");
	a_version_top: assert property (version_identifier[7])
		else $error("version top bit");
	a_oe_on_read: assert property ($rose(hostDataOe) |-> !read_strobe_n)
		else $error("drive without read");
	a_data_held: assert property (hostDataOe && $past(hostDataOe) |-> $stable(hostDataOut))
		else $error("data moved");
	a_quiet_write: assert property (!write_strobe_n |-> !hostDataOe)
		else $error("drive in write");
	a_oe_drops: assert property ($fell(hostDataOe) |-> read_strobe_n)
		else $error("early release");
endmodule
bind id_readback_commands readback_monitor mon (.*);
`default_nettype wire

// [bench/host_model.sv]
`default_nettype none
module host_model (
	input wire logic mclk,
	// Read-back from the device
	input wire logic [7:0] rdData,
	input wire logic rdOe,
	// Bus pins driven by the host
	output logic dcSel,
	output logic rdN,
	output logic wrN,
	output logic [7:0] cmdData
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {dcSel, rdN, wrN, cmdData} = 11'h700;
	// Six clocks clear the two-clock strobe minimum and the pin filter delay
	task automatic step();
		repeat (6) @(posedge mclk);
		#1;
	endtask
	// Byte taken on the rising write strobe, then the lines are scrambled
	task automatic cmd(input logic [7:0] b);
		dcSel = 0;
		cmdData = b;
		wrN = 0;
		step();
		wrN = 1;
		step();
		dcSel = 1;
		cmdData = ~b;
	endtask
	// Parameter read, sampled before the strobe is released
	task automatic rd(output logic [8:0] v);
		rdN = 0;
		step();
		v = {rdOe, rdData};
		rdN = 1;
		step();
	endtask
endmodule
`default_nettype wire

// [bench/id_readback_commands_tb.sv]
`include "id_readback_defines.svh"
`default_nettype none
module id_readback_commands_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, sys_rst, softReset, store, dcSel, rdN, wrN, rdOe;
	logic [7:0] cmdData, rdData, storedV, storedM, verId, modId;
	logic [8:0] v;
	int fail_count = 0;
	int cmp_count = 0;
	`define CHECK_EQ(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
		$display("mismatch at %0t got %h exp %h", $time, g, e); end end
	host_model host (.mclk(mclk), .rdData(rdData), .rdOe(rdOe), .dcSel(dcSel), .rdN(rdN),
		.wrN(wrN), .cmdData(cmdData));
	id_readback_commands dut (.mclk(mclk), .sys_rst(sys_rst), .softReset(softReset),
		.data_command_select(dcSel), .read_strobe_n(rdN), .write_strobe_n(wrN),
		.hostDataIn(cmdData), .hostDataOut(rdData), .hostDataOe(rdOe),
		.nonvolatile_program_store(store), .storedVersionId(storedV),
		.storedModuleId(storedM), .version_identifier(verId), .module_identifier(modId));
	// 125 MHz clock
	initial begin
		mclk = 0;
		forever #4 mclk = ~mclk;
	end
	task automatic print_verdict();
		if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Reset pulse, then time for the identifiers to load
	task automatic pulse(ref logic s, input int n);
		s = 1;
		repeat (n) @(posedge mclk);
		#1 s = 0;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	// Command, dummy read, identifier read, then one read too many
	task automatic idRead(input logic [7:0] c, input logic [7:0] id);
		host.cmd(c);
		host.rd(v);
		`CHECK_EQ(v[8], 1'b1)
		host.rd(v);
		`CHECK_EQ(v, {1'b1, id})
		host.rd(v);
		`CHECK_EQ(v[8], 1'b0)
	endtask
	initial begin
		{softReset, store, storedV, storedM} = 18'h0123c;
		pulse(sys_rst, 20);
		`CHECK_EQ(verId, `VERSION_ID_BUILTIN | `VERSION_ID_MSB)
		idRead(`CMD_READ_VERSION_ID, `VERSION_ID_BUILTIN | `VERSION_ID_MSB);
		idRead(`CMD_READ_MODULE_ID, `MODULE_ID_BUILTIN);
		// A neighbouring code must not start a read-back
		host.cmd(`CMD_READ_VERSION_ID - 8'h01);
		host.rd(v);
		`CHECK_EQ(v[8], 1'b0)
		// Programmed store takes over at a software reset; top bit still forced
		store = 1;
		pulse(softReset, 1);
		idRead(`CMD_READ_VERSION_ID, storedV | `VERSION_ID_MSB);
		idRead(`CMD_READ_MODULE_ID, storedM);
		// Blank store again: hardware reset brings back the built-in pair
		store = 0;
		pulse(sys_rst, 2);
		`CHECK_EQ(modId, `MODULE_ID_BUILTIN)
		print_verdict();
	end
	// Watchdog, far beyond the few hundred clocks needed
	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
